//--- hw/bdc_consts.vh
`ifndef BDC_CONSTS_VH
`define BDC_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define BDC_OFF_CTRL      8'h00
`define BDC_OFF_WCON1     8'h04
`define BDC_OFF_DEADBAND  8'h08
`define BDC_OFF_PHASE     8'h0c
`define BDC_OFF_BLANK     8'h10
`define BDC_OFF_STATUS    8'h14

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BDC_CTRL_EN       0
`define BDC_CTRL_FULL     1
`define BDC_CTRL_REV      2
`define BDC_CTRL_SEL_LO   4
`define BDC_WCON1_RSRC    0
`define BDC_WCON1_FSRC    1
`define BDC_WCON1_INV_LO  4
`define BDC_CNT_RISE_LO   0
`define BDC_CNT_FALL_LO   8
`define BDC_CNT_W         6

// ----------------------------------------
// Reset values
// ----------------------------------------
`define BDC_CTRL_RST      8'hf0
`define BDC_WCON1_RST     8'h03
`define BDC_CNT_RST       6'h00
`define BDC_OUT_IDLE      4'ha

// ----------------------------------------
// Bus answers
// ----------------------------------------
`define BDC_RESP_OKAY     2'b00
`define BDC_RESP_SLVERR   2'b10

`endif

//--- hw/bdc_timer.v
`timescale 1ns/10ps
`include "bdc_consts.vh"

module bdc_timer (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // Start and setting
    input wire trig,
    input wire sync_sel,
    input wire [`BDC_CNT_W-1:0] count,
    // Expiry pulse
    output wire done
);

    localparam TAPS = 1 << `BDC_CNT_W;

    reg [`BDC_CNT_W-1:0] cnt_q;
    reg [`BDC_CNT_W-1:0] cnt_d;
    reg run_q;
    reg run_d;
    wire sync_done;
    wire [TAPS-1:0] chain;

    // ----------------------------------------
    // Delay chain, no clock involved
    // ----------------------------------------
    // In RTL each element has no modelled delay; silicon sizes them
    assign chain[0] = trig;
    genvar i;
    generate
        for (i = 1; i < TAPS; i = i + 1) begin : g_el
            assign chain[i] = chain[i-1];
        end
    endgenerate

    // ----------------------------------------
    // Clocked counter
    // ----------------------------------------
    assign sync_done = (trig && count == `BDC_CNT_RST) ||
                       (run_q && cnt_q == 6'h01);

    always @* begin
        cnt_d = cnt_q;
        run_d = run_q;
        if (run_q) begin
            cnt_d = cnt_q - 6'h01;
            if (cnt_q == 6'h01) begin
                run_d = 1'b0;
            end
        end
        // A new event restarts the count only when sync_sel is set
        if (trig && sync_sel) begin
            cnt_d = count;
            run_d = count != `BDC_CNT_RST;
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            cnt_q <= `BDC_CNT_RST;
            run_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            run_q <= run_d;
        end
    end

    assign done = sync_sel ? sync_done : chain[count];

endmodule

//--- hw/bdc_core.v
`timescale 1ns/10ps
`include "bdc_consts.vh"

module bdc_core (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // AXI4-Lite write
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Modulation input
    input wire pwm_in,
    // Bridge drive, bit 0 is A
    output reg [3:0] drive_out
);

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [7:0] ctrl_q;
    reg [7:0] waveform_control_one_q;
    reg [13:0] deadband_q;
    reg [13:0] phase_q;
    reg [13:0] blank_q;

    reg [7:0] aw_addr_q;
    reg aw_have_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    reg w_have_q;

    wire en = ctrl_q[`BDC_CTRL_EN];
    wire full = ctrl_q[`BDC_CTRL_FULL];
    wire rev_cfg = ctrl_q[`BDC_CTRL_REV];
    wire [3:0] sel = ctrl_q[`BDC_CTRL_SEL_LO+3:`BDC_CTRL_SEL_LO];
    wire rise_deadtime_source_sel = waveform_control_one_q[`BDC_WCON1_RSRC];
    wire fall_deadtime_source_sel = waveform_control_one_q[`BDC_WCON1_FSRC];
    wire [3:0] out_invert =
        waveform_control_one_q[`BDC_WCON1_INV_LO+3:`BDC_WCON1_INV_LO];

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire [7:0] wa = aw_take ? s_axi_awaddr : aw_addr_q;
    wire [31:0] wd = w_take ? s_axi_wdata : w_data_q;
    wire [3:0] ws = w_take ? s_axi_wstrb : w_strb_q;
    wire wr_go = (aw_take || aw_have_q) && (w_take || w_have_q) &&
                 !s_axi_bvalid;
    wire wa_ok = wa == `BDC_OFF_CTRL || wa == `BDC_OFF_WCON1 ||
                 wa == `BDC_OFF_DEADBAND || wa == `BDC_OFF_PHASE ||
                 wa == `BDC_OFF_BLANK;

    always @(posedge clk) begin
        if (sys_rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `BDC_RESP_OKAY;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_addr_q <= s_axi_awaddr;
                aw_have_q <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (w_take) begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
                w_have_q <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wa_ok ? `BDC_RESP_OKAY : `BDC_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            ctrl_q <= `BDC_CTRL_RST;
            waveform_control_one_q <= `BDC_WCON1_RST;
            deadband_q <= 14'h0000;
            phase_q <= 14'h0000;
            blank_q <= 14'h0000;
        end else if (wr_go) begin
            case (wa)
                `BDC_OFF_CTRL: begin
                    if (ws[0]) ctrl_q <= wd[7:0];
                end
                `BDC_OFF_WCON1: begin
                    if (ws[0]) waveform_control_one_q <= wd[7:0];
                end
                `BDC_OFF_DEADBAND: begin
                    if (ws[0]) deadband_q[5:0] <= wd[5:0];
                    if (ws[1]) deadband_q[13:8] <= wd[13:8];
                end
                `BDC_OFF_PHASE: begin
                    if (ws[0]) phase_q[5:0] <= wd[5:0];
                    if (ws[1]) phase_q[13:8] <= wd[13:8];
                end
                `BDC_OFF_BLANK: begin
                    if (ws[0]) blank_q[5:0] <= wd[5:0];
                    if (ws[1]) blank_q[13:8] <= wd[13:8];
                end
                default: begin
                end
            endcase
        end
    end

    reg dir_q;
    reg hold_q;
    reg prim_q;
    reg comp_q;
    reg mod_q;
    reg [31:0] rd_d;
    reg rd_ok;

    always @* begin
        rd_ok = 1'b1;
        rd_d = 32'h00000000;
        case (s_axi_araddr)
            `BDC_OFF_CTRL: rd_d[7:0] = ctrl_q;
            `BDC_OFF_WCON1: rd_d[7:0] = waveform_control_one_q;
            `BDC_OFF_DEADBAND: rd_d[13:0] = deadband_q;
            `BDC_OFF_PHASE: rd_d[13:0] = phase_q;
            `BDC_OFF_BLANK: rd_d[13:0] = blank_q;
            `BDC_OFF_STATUS:
                rd_d[7:0] = {comp_q, prim_q, hold_q, dir_q, drive_out};
            default: rd_ok = 1'b0;
        endcase
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `BDC_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_d;
                s_axi_rresp <= rd_ok ? `BDC_RESP_OKAY : `BDC_RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Event detection and blanking
    // ----------------------------------------
    reg pwm_prev_q;
    reg [5:0] rblank_q;
    reg [5:0] fblank_q;
    wire ph_r_done;
    wire ph_f_done;
    wire db_r_done;
    wire db_f_done;

    wire rise_ev = en && pwm_in && !pwm_prev_q && rblank_q == 6'h00;
    wire fall_ev = en && !pwm_in && pwm_prev_q && fblank_q == 6'h00;

    always @(posedge clk) begin
        if (sys_rst) begin
            pwm_prev_q <= 1'b0;
            rblank_q <= 6'h00;
            fblank_q <= 6'h00;
        end else begin
            pwm_prev_q <= pwm_in;
            if (ph_r_done) begin
                fblank_q <= blank_q[13:8];
            end else if (fblank_q != 6'h00) begin
                fblank_q <= fblank_q - 6'h01;
            end
            if (ph_f_done) begin
                rblank_q <= blank_q[5:0];
            end else if (rblank_q != 6'h00) begin
                rblank_q <= rblank_q - 6'h01;
            end
        end
    end

    // ----------------------------------------
    // Phase and dead-band timers
    // ----------------------------------------
    // Reversal is only taken while no earlier one is pending
    wire chg = en && full && !hold_q && rev_cfg != dir_q;
    wire db_r_trig = full ? (chg && !rev_cfg) : ph_r_done;
    wire db_f_trig = full ? (chg && rev_cfg) : ph_f_done;

    bdc_timer u_ph_rise (
        .clk(clk),
        .sys_rst(sys_rst),
        .trig(rise_ev),
        .sync_sel(1'b1),
        .count(phase_q[5:0]),
        .done(ph_r_done)
    );

    bdc_timer u_ph_fall (
        .clk(clk),
        .sys_rst(sys_rst),
        .trig(fall_ev),
        .sync_sel(1'b1),
        .count(phase_q[13:8]),
        .done(ph_f_done)
    );

    bdc_timer u_db_rise (
        .clk(clk),
        .sys_rst(sys_rst),
        .trig(db_r_trig),
        .sync_sel(rise_deadtime_source_sel),
        .count(deadband_q[5:0]),
        .done(db_r_done)
    );

    bdc_timer u_db_fall (
        .clk(clk),
        .sys_rst(sys_rst),
        .trig(db_f_trig),
        .sync_sel(fall_deadtime_source_sel),
        .count(deadband_q[13:8]),
        .done(db_f_done)
    );

    // ----------------------------------------
    // Output state
    // ----------------------------------------
    // Arm flags stop a stale dead-band expiry from a cut-short pulse
    reg r_arm_q;
    reg f_arm_q;

    always @(posedge clk) begin
        if (sys_rst || !en) begin
            prim_q <= 1'b0;
            comp_q <= 1'b1;
            mod_q <= 1'b0;
            r_arm_q <= 1'b0;
            f_arm_q <= 1'b0;
        end else begin
            // Rising edge wins when two land in one cycle
            if (db_f_done && (f_arm_q || ph_f_done) && !full) begin
                comp_q <= 1'b1;
            end
            if (db_r_done && (r_arm_q || ph_r_done) && !full) begin
                prim_q <= 1'b1;
            end
            if (ph_f_done) begin
                prim_q <= 1'b0;
                mod_q <= 1'b0;
                f_arm_q <= 1'b1;
                r_arm_q <= 1'b0;
            end
            if (ph_r_done) begin
                comp_q <= 1'b0;
                mod_q <= 1'b1;
                r_arm_q <= 1'b1;
                f_arm_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Direction in full-bridge mode
    // ----------------------------------------
    always @(posedge clk) begin
        if (sys_rst) begin
            dir_q <= 1'b0;
            hold_q <= 1'b0;
        end else if (!en || !full) begin
            dir_q <= rev_cfg;
            hold_q <= 1'b0;
        end else if (db_r_done || db_f_done) begin
            dir_q <= !dir_q;
            hold_q <= 1'b0;
        end else if (chg) begin
            hold_q <= 1'b1;
        end
    end

    // ----------------------------------------
    // Drive pins
    // ----------------------------------------
    reg [3:0] act;

    always @* begin
        if (!en) begin
            act = `BDC_OUT_IDLE;
        end else if (!full) begin
            act = {comp_q, prim_q, comp_q, prim_q} & sel;
        end else if (hold_q || chg) begin
            // Whole bridge off while the reversal dead-band runs
            act = 4'h0;
        end else if (dir_q) begin
            act = {1'b0, 1'b1, mod_q, 1'b0} & sel;
        end else begin
            act = {mod_q, 1'b0, 1'b0, 1'b1} & sel;
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            drive_out <= `BDC_OUT_IDLE;
        end else begin
            drive_out <= act ^ out_invert;
        end
    end

endmodule

//--- test/bdc_core_sva.sv
`timescale 1ns/10ps
module bdc_core_sva (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // Register bus
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    // Drive
    input wire pwm_in,
    input wire [3:0] drive_out
);
    // ------------
    // Settings shadow
    // ------------
    reg [7:0] ctl_q;
    reg [7:0] wc_q;
    reg [5:0] dr_q;
    reg [5:0] df_q;
    reg pwm_q;
    reg [7:0] cr_q;
    reg [7:0] cf_q;
    wire wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire [3:0] eff = drive_out ^ wc_q[7:4];
    wire half = ctl_q[0] && !ctl_q[1];

    // Full-word writes only; a partial strobe still loads the whole shadow
    always @(posedge clk) begin
        pwm_q <= pwm_in;
        cr_q <= (pwm_in && !pwm_q) ? 8'h00 : cr_q + {7'h00, ~&cr_q};
        cf_q <= (!pwm_in && pwm_q) ? 8'h00 : cf_q + {7'h00, ~&cf_q};
        if (sys_rst) begin
            ctl_q <= 8'hf0;
            wc_q <= 8'h03;
            dr_q <= 6'h00;
            df_q <= 6'h00;
        end else if (wr && s_axi_awaddr == 8'h00) begin
            ctl_q <= s_axi_wdata[7:0];
        end else if (wr && s_axi_awaddr == 8'h04) begin
            wc_q <= s_axi_wdata[7:0];
        end else if (wr && s_axi_awaddr == 8'h08) begin
            dr_q <= s_axi_wdata[5:0];
            df_q <= s_axi_wdata[13:8];
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    // ------------
    // Properties
    // ------------
    AST_RST_IDLE: assert property (
        $fell(sys_rst) |-> drive_out == 4'ha) else $error("not idle");
    AST_OFF_IDLE: assert property (
        !ctl_q[0] && !$past(ctl_q[0]) && $stable(wc_q) |-> eff == 4'ha)
        else $error("disabled drive wrong");
    AST_LEG_AB: assert property (
        $stable(wc_q) |-> !(eff[0] && eff[1])) else $error("A,B overlap");
    AST_LEG_CD: assert property (
        $stable(wc_q) |-> !(eff[2] && eff[3])) else $error("C,D overlap");
    AST_RISE_GAP: assert property (
        half && wc_q[0] && $rose(eff[0]) && $stable(wc_q) |->
        cr_q >= {2'h0, dr_q} && cr_q <= {2'h0, dr_q} + 8'h03)
        else $error("rise dead-band wrong");
    AST_FALL_GAP: assert property (
        half && wc_q[1] && $rose(eff[1]) && $stable(wc_q) |->
        cf_q >= {2'h0, df_q} && cf_q <= {2'h0, df_q} + 8'h03)
        else $error("fall dead-band wrong");
    AST_PAIRS: assert property (
        half && $stable(ctl_q) && $stable(wc_q) |->
        eff[0] == eff[2] && eff[1] == eff[3]) else $error("pairs differ");
    AST_B_TURN: assert property (
        wr |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
        else $error("write answer wrong");
    AST_B_DROP: assert property (
        s_axi_bvalid && s_axi_bready |=>
        !s_axi_bvalid && s_axi_awready && s_axi_wready)
        else $error("write answer not released");
    COV_RISE: cover property (half && $rose(eff[0]));
    COV_DIR: cover property (ctl_q[1] && drive_out == 4'h0);
    COV_WR: cover property (wr);
endmodule

//--- test/bdc_bridge_model.sv
`timescale 1ns/10ps
module bdc_bridge_model (
    // Clock
    input wire clk,
    // Gate drives and their polarity
    input wire [3:0] gate,
    input wire [3:0] inv,
    // Shoot-through tally
    output reg [7:0] shoot_cnt
);
    wire [3:0] on = gate ^ inv;

    initial shoot_cnt = 8'h00;
    // Both switches of one leg on would short the supply rail
    always @(posedge clk) begin
        if ((on[0] && on[1]) || (on[2] && on[3])) begin
            shoot_cnt <= shoot_cnt + 8'h01;
        end
    end
endmodule

//--- test/bridge_deadband_control_bench.sv
`timescale 1ns/10ps
module bridge_deadband_control_bench;
    reg clk, sys_rst, pwm_in, awvalid, wvalid, bready, arvalid, rready;
    reg [7:0] awaddr, araddr;
    reg [31:0] wdata, rd;
    reg [3:0] wstrb, inv;
    wire awready, wready, bvalid, arready, rvalid;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [3:0] drive_out;
    wire [7:0] shoot_cnt;
    integer num_errors, comparisons, k;

    bdc_core u_dut (
        .clk(clk), .sys_rst(sys_rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pwm_in(pwm_in), .drive_out(drive_out)
    );
    bdc_bridge_model u_bridge (
        .clk(clk), .gate(drive_out), .inv(inv), .shoot_cnt(shoot_cnt)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ------------
    // Shared tasks
    // ------------
    task test_done;
        begin
            $display("errors %0d, checks %0d", num_errors, comparisons);
            if (num_errors == 0 && comparisons > 0) begin
                $display("Run complete: PASS");
            end else begin
                $display("Run complete: FAIL");
            end
            $finish;
        end
    endtask

    task check(input [31:0] got, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("mismatch at %0t: %h vs %h", $time, got, exp);
            end
        end
    endtask

    task timeout;
        begin
            num_errors = num_errors + 1;
            $display("mismatch at %0t: stuck %h vs %h", $time, drive_out, 0);
            test_done;
        end
    endtask

    task wr(input [7:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
        integer i;
        reg fin;
        begin
            @(posedge clk);
            awaddr <= a;
            wdata <= d;
            wstrb <= s;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            fin = 1'b0;
            for (i = 0; i < 50 && !fin; i = i + 1) begin
                @(posedge clk);
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
                if (bvalid) begin
                    bready <= 1'b0;
                    fin = 1'b1;
                    check({30'h0, bresp}, {30'h0, er});
                end
            end
            if (!fin) timeout;
        end
    endtask

    task rdr(input [7:0] a, input [1:0] er);
        integer i;
        reg fin;
        begin
            @(posedge clk);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            fin = 1'b0;
            for (i = 0; i < 50 && !fin; i = i + 1) begin
                @(posedge clk);
                if (arready) arvalid <= 1'b0;
                if (rvalid) begin
                    rready <= 1'b0;
                    fin = 1'b1;
                    rd = rdata;
                    check({30'h0, rresp}, {30'h0, er});
                end
            end
            if (!fin) timeout;
        end
    endtask

    // Counts edges until the pins show t
    task settle(input [3:0] t);
        begin
            k = 0;
            while (drive_out !== t && k < 300) begin
                @(posedge clk);
                #1;
                k = k + 1;
            end
            if (k >= 300) timeout;
        end
    endtask

    task step(input p, input [3:0] t, input integer n);
        begin
            @(posedge clk);
            pwm_in <= p;
            settle(t);
            check(k, n);
        end
    endtask

    // ------------
    // Scenarios
    // ------------
    task t_regs;
        begin
            check(drive_out, 4'ha);
            rdr(8'h00, 2'b00);
            check(rd, 32'hf0);
            rdr(8'h04, 2'b00);
            check(rd, 32'h03);
            rdr(8'h14, 2'b00);
            check(rd[3:0], 4'ha);
            rdr(8'h1c, 2'b10);
            wr(8'h14, 32'hff, 4'hf, 2'b10);
            wr(8'h08, 32'h0505, 4'hf, 2'b00);
            wr(8'h08, 32'h0909, 4'h1, 2'b00);
            rdr(8'h08, 2'b00);
            check(rd, 32'h0509);
        end
    endtask

    task t_half;
        begin
            wr(8'h08, 32'h0503, 4'hf, 2'b00);
            wr(8'h00, 32'hf1, 4'hf, 2'b00);
            check(drive_out, 4'ha);
            step(1'b1, 4'h5, 5);
            step(1'b0, 4'ha, 7);
            wr(8'h08, 32'h0000, 4'hf, 2'b00);
            step(1'b1, 4'h5, 2);
            step(1'b0, 4'ha, 2);
            wr(8'h08, 32'h0503, 4'hf, 2'b00);
            wr(8'h04, 32'h02, 4'hf, 2'b00);
            step(1'b1, 4'h5, 2);
            step(1'b0, 4'ha, 7);
            wr(8'h04, 32'h53, 4'hf, 2'b00);
            inv <= 4'h5;
            settle(4'hf);
            step(1'b1, 4'h0, 5);
            step(1'b0, 4'hf, 7);
            wr(8'h04, 32'h03, 4'hf, 2'b00);
            inv <= 4'h0;
        end
    endtask

    task t_blank;
        begin
            wr(8'h0c, 32'h0002, 4'hf, 2'b00);
            step(1'b1, 4'h5, 7);
            wr(8'h0c, 32'h0000, 4'hf, 2'b00);
            wr(8'h10, 32'h0008, 4'hf, 2'b00);
            step(1'b0, 4'ha, 7);
            // Rise inside the rising-input blank must be ignored
            @(posedge clk);
            pwm_in <= 1'b1;
            repeat (6) @(posedge clk);
            #1;
            check(drive_out, 4'ha);
            @(posedge clk);
            pwm_in <= 1'b0;
            wr(8'h10, 32'h0000, 4'hf, 2'b00);
            repeat (10) @(posedge clk);
        end
    endtask

    task t_full;
        begin
            wr(8'h08, 32'h0509, 4'hf, 2'b00);
            wr(8'h00, 32'hf3, 4'hf, 2'b00);
            settle(4'h1);
            step(1'b1, 4'h9, 2);
            step(1'b0, 4'h1, 2);
            wr(8'h00, 32'hf7, 4'hf, 2'b00);
            settle(4'h4);
            check(k >= 4 && k <= 6, 1);
            step(1'b1, 4'h6, 2);
            step(1'b0, 4'h4, 2);
            wr(8'h00, 32'hf3, 4'hf, 2'b00);
            settle(4'h1);
            check(k >= 8 && k <= 10, 1);
            wr(8'h00, 32'hf0, 4'hf, 2'b00);
            settle(4'ha);
            check(k <= 3, 1);
        end
    endtask

    initial begin
        sys_rst = 1'b1;
        pwm_in = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hf;
        inv = 4'h0;
        num_errors = 0;
        comparisons = 0;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        t_regs;
        t_half;
        t_blank;
        t_full;
        check({24'h0, shoot_cnt}, 32'h0);
        test_done;
    end
endmodule

bind bdc_core bdc_core_sva u_sva (
    .clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .pwm_in(pwm_in), .drive_out(drive_out)
);
